//--- logic/grs_regs.vh
// constants for the gear resolution parameter setup block
`ifndef GRS_REGS_VH
`define GRS_REGS_VH
// ==========================================
// parameter select codes (write and read port)
`define GRS_SEL_ACT_MECH 4'h0
`define GRS_SEL_ACT_DEN 4'h1
`define GRS_SEL_ACT_NUM 4'h2
`define GRS_SEL_PRESET 4'h3
`define GRS_SEL_ST_MECH 4'h4
`define GRS_SEL_ST_DEN 4'h5
`define GRS_SEL_ST_NUM 4'h6
`define GRS_SEL_SEN_PRES 4'h8
`define GRS_SEL_SEN_DEN 4'h9
`define GRS_SEL_SEN_NUM 4'ha
`define GRS_SEL_RES_LO 4'hc
`define GRS_SEL_RES_HI 4'hd
`define GRS_SEL_STATUS 4'he
// ==========================================
// reset values
`define GRS_MECH_RST 8'h00
`define GRS_GEAR_RST 16'h0001
`define GRS_PRESET_RST 16'h0000
`define GRS_MECH_SENSOR 8'h00
`define GRS_MECH_MANUAL 8'h01
// ==========================================
// resolution arithmetic and legal range
`define GRS_RES_BASE 30'h0002710
`define GRS_RES_MIN 30'h0000064
`define GRS_RES_MAX 30'h0002710
`define GRS_RES_DEFAULT 30'h0002710
// ==========================================
// status word bit positions
`define GRS_ST_WARN 0
`define GRS_ST_ALARM 1
`define GRS_ST_SENSOR 2
`define GRS_ST_COPY 3
`define GRS_ST_BUSY 4
`define GRS_ST_REDO 5
`define GRS_ST_MECHP 6
// boot wait, covers the two-stage synchroniser
`define GRS_BOOT_LOAD 2'h2
`define GRS_BOOT_DONE 2'h3
`endif

//--- logic/grs_divider.v
// sequential restoring divider for the resolution quotient
`default_nettype none
module grs_divider #(
  parameter WN = 30,
  parameter WD = 16,
  parameter CW = 5
) (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [WN-1:0] dividend,
  input wire [WD-1:0] divisor,
  output reg busy,
  output reg done,
  output reg [WN-1:0] quotient,
  output reg rem_nz
);
  reg [WN-1:0] quo;
  reg [WD-1:0] rem;
  reg [CW-1:0] cnt;
  // divisor held for the whole divide, so a gear write mid-divide cannot corrupt it
  reg [WD-1:0] dvs;
  wire [WD:0] trial = {rem, quo[WN-1]};
  wire fits = (trial >= {1'b0, dvs});
  wire [WD:0] diff = trial - {1'b0, dvs};
  // ==========================================
  // one quotient bit per clock; write checks refuse a zero divisor, but a sensor copy can still load one
  always @(posedge clk) begin
    if (rst) begin
      quo <= {WN{1'b0}};
      rem <= {WD{1'b0}};
      dvs <= {WD{1'b0}};
      cnt <= {CW{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
      quotient <= {WN{1'b0}};
      rem_nz <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        quo <= dividend;
        dvs <= divisor;
        rem <= {WD{1'b0}};
        cnt <= WN[CW-1:0];
        busy <= 1'b1;
      end else if (busy) begin
        rem <= fits ? diff[WD-1:0] : trial[WD-1:0];
        quo <= {quo[WN-2:0], fits};
        cnt <= cnt - {{(CW-1){1'b0}}, 1'b1};
        if (cnt == {{(CW-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
          quotient <= {quo[WN-2:0], fits};
          rem_nz <= fits ? (diff[WD-1:0] != {WD{1'b0}}) : (trial[WD-1:0] != {WD{1'b0}});
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- logic/grs_alarm.v
// range check, gear warning and gear alarm latch
`default_nettype none
`include "grs_regs.vh"
module grs_alarm (
  input wire clk,
  input wire rst,
  input wire chk_valid,
  input wire [29:0] res,
  input wire rem_nz,
  input wire reapply,
  input wire config_cmd,
  input wire alarm_clr,
  output reg warn,
  output reg alarm
);
  // a fraction above the top value is still above the legal range
  wire out_of_range = (res < `GRS_RES_MIN) || (res > `GRS_RES_MAX) ||
                      ((res == `GRS_RES_MAX) && rem_nz);
  // ==========================================
  // warning follows each fresh check and never stops the drive
  always @(posedge clk) begin
    if (rst) begin
      warn <= 1'b0;
    end else if (chk_valid) begin
      warn <= out_of_range; // R12
    end
  end
  // ==========================================
  // alarm is sticky; a set in the clear cycle wins
  always @(posedge clk) begin
    if (rst) begin
      alarm <= 1'b0;
    end else if (warn && (reapply || config_cmd)) begin
      alarm <= 1'b1; // R13
    end else if (alarm_clr) begin
      alarm <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- logic/grs_top.v
// gear resolution parameter setup: source select, gear store, resolution check
// Operation
// R1 - factory default uses sensor fixed values first
// R2 - any host write switches all parameters to driver
// R3 - sensor fixed values are read only
// R4 - manually written parameters survive a sensor copy
// R5 - copied values apply after control power cycle
// R6 - report active, stored and sensor views separately
// R7 - resolution equals 10000 times numerator over denominator
// R8 - legal resolution 100 to 10000, default 10000
// R9 - gear values 1 to 65535, reset 1
// R10 - mechanism source 0 sensor, 1 manual, reset 0
// R11 - mechanism source change applies after power cycle
// R12 - out of range resolution raises warning only
// R13 - power cycle or configure with warning raises alarm
// R14 - host repeats preset when preset nonzero
// R15 - zero preset recalculates position on resolution change
// R16 - reset resolution taken from sensor when present
// R17 - recompute and check after every gear write
`default_nettype none
`include "grs_regs.vh"
module grs_top (
  input wire clk,
  input wire rst,
  input wire wr_en,
  input wire [3:0] wr_sel,
  input wire [15:0] wr_data,
  input wire copy_cmd,
  input wire config_cmd,
  input wire alarm_clr,
  input wire [3:0] rd_sel,
  input wire power_cycle,
  input wire sensor_present,
  input wire [15:0] sensor_den,
  input wire [15:0] sensor_num,
  output reg [15:0] rd_data,
  output reg wr_ack,
  output reg wr_err,
  output reg [29:0] resolution,
  output reg res_valid,
  output reg gear_warn,
  output reg gear_alarm,
  output reg using_sensor,
  output reg pos_recalc,
  output reg preset_redo
);
  // ==========================================
  // synchronisers for pins from outside the clock domain
  reg s1_pres;
  reg s2_pres;
  reg [15:0] s1_den;
  reg [15:0] s2_den;
  reg [15:0] s1_num;
  reg [15:0] s2_num;
  reg s1_pwr;
  reg s2_pwr;
  reg s3_pwr;
  // static sensor data; a short skew while it settles is covered by boot wait
  always @(posedge clk) begin
    if (rst) begin
      s1_pres <= 1'b0;
      s2_pres <= 1'b0;
      s1_den <= `GRS_GEAR_RST;
      s2_den <= `GRS_GEAR_RST;
      s1_num <= `GRS_GEAR_RST;
      s2_num <= `GRS_GEAR_RST;
      s1_pwr <= 1'b0;
      s2_pwr <= 1'b0;
      s3_pwr <= 1'b0;
    end else begin
      s1_pres <= sensor_present;
      s2_pres <= s1_pres;
      s1_den <= sensor_den;
      s2_den <= s1_den;
      s1_num <= sensor_num;
      s2_num <= s1_num;
      s1_pwr <= power_cycle;
      s2_pwr <= s1_pwr;
      s3_pwr <= s2_pwr;
    end
  end
  // control power re-applied: rising edge of the synchronised level
  wire reapply = s2_pwr && !s3_pwr;
  // a zero gear from the sensor would be illegal, so fall back to driver data
  wire sen_ok = s2_pres && (s2_den != 16'h0000) && (s2_num != 16'h0000);
  // ==========================================
  // boot sequencer: one load after the synchronisers have filled
  reg [1:0] boot_cnt;
  always @(posedge clk) begin
    if (rst) begin
      boot_cnt <= 2'h0;
    end else if (boot_cnt != `GRS_BOOT_DONE) begin
      boot_cnt <= boot_cnt + 2'h1;
    end
  end
  wire boot_load = (boot_cnt == `GRS_BOOT_LOAD);
  wire load = boot_load || reapply;
  // ==========================================
  // parameter state
  reg [7:0] st_mech;
  reg [15:0] st_den;
  reg [15:0] st_num;
  reg [15:0] preset;
  reg [7:0] act_mech;
  reg [15:0] act_den;
  reg [15:0] act_num;
  reg drv_pref;
  reg copy_pend;
  reg man_den;
  reg man_num;
  // ==========================================
  // write decode and legality
  wire is_mech = (wr_sel == `GRS_SEL_ACT_MECH) || (wr_sel == `GRS_SEL_ST_MECH);
  wire is_den = (wr_sel == `GRS_SEL_ACT_DEN) || (wr_sel == `GRS_SEL_ST_DEN);
  wire is_num = (wr_sel == `GRS_SEL_ACT_NUM) || (wr_sel == `GRS_SEL_ST_NUM);
  wire is_pre = (wr_sel == `GRS_SEL_PRESET);
  wire gear_zero = (wr_data == 16'h0000);
  wire mech_bad = (wr_data > {8'h00, `GRS_MECH_MANUAL});
  wire manual_on = (act_mech == `GRS_MECH_MANUAL);
  reg wr_ok;
  // sensor views, status and unknown codes fall out as refusals
  always @* begin
    wr_ok = 1'b0;
    if (is_mech) begin
      wr_ok = !mech_bad; // R10
    end else if (is_den || is_num) begin
      wr_ok = manual_on && !gear_zero; // R9
    end else if (is_pre) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0; // R3
    end
  end
  wire acc = wr_en && wr_ok;
  // a write in the same cycle wins; the copy is then dropped with no answer
  wire copy_ok = copy_cmd && s2_pres && !wr_en;
  wire drv_after = drv_pref || copy_pend;
  // ==========================================
  // driver memory: host writes and sensor copy
  always @(posedge clk) begin
    if (rst) begin
      st_mech <= `GRS_MECH_RST;
      st_den <= `GRS_GEAR_RST;
      st_num <= `GRS_GEAR_RST;
      preset <= `GRS_PRESET_RST;
      man_den <= 1'b0;
      man_num <= 1'b0;
    end else if (acc) begin
      if (is_mech) begin
        st_mech <= wr_data[7:0];
      end
      if (is_den) begin
        st_den <= wr_data;
        man_den <= 1'b1; // R4
      end
      if (is_num) begin
        st_num <= wr_data;
        man_num <= 1'b1; // R4
      end
      if (is_pre) begin
        preset <= wr_data;
      end
    end else if (copy_ok) begin
      // manual values written earlier are kept
      if (!man_den) begin
        st_den <= s2_den; // R4
      end
      if (!man_num) begin
        st_num <= s2_num; // R4
      end
    end
  end
  // ==========================================
  // source preference and copy pending flag
  always @(posedge clk) begin
    if (rst) begin
      drv_pref <= 1'b0; // R1
      copy_pend <= 1'b0;
    end else begin
      if (acc) begin
        drv_pref <= 1'b1; // R2
      end else if (reapply) begin
        drv_pref <= drv_after;
      end
      if (copy_ok) begin
        copy_pend <= 1'b1; // R5
      end else if (reapply) begin
        copy_pend <= 1'b0;
      end
    end
  end
  // ==========================================
  // values in effect; reload at boot and at every power cycle
  always @(posedge clk) begin
    if (rst) begin
      act_mech <= `GRS_MECH_RST;
      act_den <= `GRS_GEAR_RST;
      act_num <= `GRS_GEAR_RST;
    end else if (load) begin
      act_mech <= st_mech; // R11
      if (sen_ok && !drv_after && (st_mech == `GRS_MECH_SENSOR)) begin
        act_den <= s2_den; // R16
        act_num <= s2_num; // R1
      end else begin
        act_den <= st_den; // R5
        act_num <= st_num; // R2
      end
    end else if (acc && is_den) begin
      act_den <= wr_data; // R17
    end else if (acc && is_num) begin
      act_num <= wr_data; // R17
    end
  end
  // ==========================================
  // resolution request: any change of the gears in effect
  reg calc_req;
  wire div_busy;
  wire div_done;
  wire [29:0] div_q;
  wire div_rem;
  wire gear_chg = load || (acc && (is_den || is_num));
  // a write during a divide is held over and recomputed afterwards
  always @(posedge clk) begin
    if (rst) begin
      calc_req <= 1'b0;
    end else if (gear_chg) begin
      calc_req <= 1'b1; // R17
    end else if (!div_busy) begin
      calc_req <= 1'b0;
    end
  end
  wire div_start = calc_req && !div_busy && !gear_chg;
  wire [29:0] dividend = {14'h0000, act_num} * `GRS_RES_BASE; // R7
  grs_divider #(
    .WN(30),
    .WD(16),
    .CW(5)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .start(div_start),
    .dividend(dividend),
    .divisor(act_den),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_q),
    .rem_nz(div_rem)
  );
  // ==========================================
  // range check and alarm
  wire warn_w;
  wire alarm_w;
  grs_alarm u_alm (
    .clk(clk),
    .rst(rst),
    .chk_valid(div_done),
    .res(div_q),
    .rem_nz(div_rem),
    .reapply(reapply),
    .config_cmd(config_cmd),
    .alarm_clr(alarm_clr),
    .warn(warn_w),
    .alarm(alarm_w)
  );
  // ==========================================
  // resolution output and position follow-up
  reg res_known;
  always @(posedge clk) begin
    if (rst) begin
      resolution <= `GRS_RES_DEFAULT; // R8
      res_known <= 1'b0;
      res_valid <= 1'b0;
      pos_recalc <= 1'b0;
      preset_redo <= 1'b0;
    end else begin
      pos_recalc <= 1'b0;
      res_valid <= div_done;
      // clear first, so a change in the preset write cycle still sets the flag
      if (acc && is_pre) begin
        preset_redo <= 1'b0;
      end
      if (div_done) begin
        resolution <= div_q; // R7
        res_known <= 1'b1;
        // the first result after reset is no change of resolution
        if (res_known && (div_q != resolution)) begin
          if (preset == `GRS_PRESET_RST) begin
            pos_recalc <= 1'b1; // R15
          end else begin
            preset_redo <= 1'b1; // R14
          end
        end
      end
    end
  end
  // ==========================================
  // status flags mirrored onto registered outputs
  always @(posedge clk) begin
    if (rst) begin
      gear_warn <= 1'b0;
      gear_alarm <= 1'b0;
      using_sensor <= 1'b1;
      wr_ack <= 1'b0;
      wr_err <= 1'b0;
    end else begin
      gear_warn <= warn_w; // R12
      gear_alarm <= alarm_w; // R13
      using_sensor <= !drv_pref; // R1
      wr_ack <= acc || copy_ok;
      wr_err <= (wr_en && !wr_ok) || (copy_cmd && !s2_pres && !wr_en); // R3
    end
  end
  // ==========================================
  // read port: three separate parameter views plus status
  wire [15:0] status = {9'h000, (st_mech != act_mech), preset_redo, div_busy || calc_req,
                        copy_pend, !drv_pref, alarm_w, warn_w};
  reg [15:0] next_rd;
  always @* begin
    case (rd_sel)
      `GRS_SEL_ACT_MECH: next_rd = {8'h00, act_mech}; // R6
      `GRS_SEL_ACT_DEN: next_rd = act_den;
      `GRS_SEL_ACT_NUM: next_rd = act_num;
      `GRS_SEL_PRESET: next_rd = preset;
      `GRS_SEL_ST_MECH: next_rd = {8'h00, st_mech}; // R6
      `GRS_SEL_ST_DEN: next_rd = st_den;
      `GRS_SEL_ST_NUM: next_rd = st_num;
      `GRS_SEL_SEN_PRES: next_rd = {15'h0000, s2_pres}; // R6
      `GRS_SEL_SEN_DEN: next_rd = s2_den;
      `GRS_SEL_SEN_NUM: next_rd = s2_num;
      `GRS_SEL_RES_LO: next_rd = resolution[15:0];
      `GRS_SEL_RES_HI: next_rd = {2'h0, resolution[29:16]};
      `GRS_SEL_STATUS: next_rd = status;
      default: next_rd = 16'h0000;
    endcase
  end
  // read data lags the select by one clock
  always @(posedge clk) begin
    if (rst) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= next_rd;
    end
  end
endmodule
`default_nettype wire

//--- bench/grs_chk.sv
// checker on the ports of the gear resolution block
`default_nettype none
module grs_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [3:0] wr_sel,
  input wire logic [15:0] wr_data,
  input wire logic copy_cmd,
  input wire logic alarm_clr,
  input wire logic [29:0] resolution,
  input wire logic res_valid,
  input wire logic wr_ack,
  input wire logic wr_err,
  input wire logic gear_warn,
  input wire logic gear_alarm,
  input wire logic using_sensor
);
  timeunit 1ns;
  timeprecision 1ns;
  // =====
  // one clock domain, reset masks everything
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  one_answer_a: assert property (!(wr_ack && wr_err))
    else $error("ack and err together");
  sensor_ro_a: assert property (wr_en && wr_sel[3] |=> wr_err)
    else $error("sensor or status write accepted");
  zero_gear_a: assert property (wr_en && wr_sel inside {4'h1, 4'h2, 4'h5, 4'h6} && !wr_data |=> wr_err)
    else $error("zero gear accepted");
  bad_mech_a: assert property (wr_en && wr_sel inside {4'h0, 4'h4} && wr_data > 16'h0001 |=> wr_err)
    else $error("mechanism code above one accepted");
  ack_cause_a: assert property (wr_ack |-> $past(wr_en || copy_cmd))
    else $error("ack without request");
  warn_out_a: assert property (res_valid && (resolution < 30'h64 || resolution > 30'h2710) |=> gear_warn)
    else $error("out of range without warning");
  warn_in_a: assert property (res_valid && resolution >= 30'h64 && resolution < 30'h2710 |=> !gear_warn)
    else $error("legal resolution warned");
  recalc_bound_a: assert property (wr_en && wr_sel == 4'h2 ##1 wr_ack |-> ##[1:40] res_valid)
    else $error("no new resolution after gear write");
  alarm_hold_a: assert property (gear_alarm && !alarm_clr && !$past(alarm_clr) |=> gear_alarm)
    else $error("alarm dropped without clear");
  boot_sensor_a: assert property ($fell(rst) |-> using_sensor)
    else $error("sensor values not preferred after reset");
endmodule
bind grs_top grs_chk u_chk (.clk, .rst, .wr_en, .wr_sel, .wr_data, .copy_cmd, .alarm_clr, .resolution,
  .res_valid, .wr_ack, .wr_err, .gear_warn, .gear_alarm, .using_sensor);
`default_nettype wire

//--- bench/grs_host.sv
// host setup model: parameter writes, reads and control power cycling
`default_nettype none
module grs_host (
  input wire logic clk,
  input wire logic wr_ack,
  input wire logic wr_err,
  input wire logic [15:0] rd_data,
  output logic wr_en,
  output logic [3:0] wr_sel,
  output logic [15:0] wr_data,
  output logic copy_cmd,
  output logic config_cmd,
  output logic alarm_clr,
  output logic [3:0] rd_sel,
  output logic power_cycle
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle host, control power present
  initial begin
    {wr_en, copy_cmd, config_cmd, alarm_clr} = 4'h0;
    {wr_sel, rd_sel} = 8'h00;
    wr_data = 16'h0000;
    power_cycle = 1'b1;
  end
  // =====
  // one request pulse {write, copy, config, clear}; answer one edge later
  task automatic req(input logic [3:0] k, input logic [3:0] s, input logic [15:0] d, output logic [1:0] r);
    @(negedge clk);
    {wr_en, copy_cmd, config_cmd, alarm_clr} = k;
    wr_sel = s;
    wr_data = d;
    @(negedge clk);
    {wr_en, copy_cmd, config_cmd, alarm_clr} = 4'h0;
    r = {wr_ack, wr_err};
  endtask
  // read data lags the select by one edge
  task automatic rd(input logic [3:0] s, output logic [15:0] v);
    @(negedge clk);
    rd_sel = s;
    @(negedge clk);
    v = rd_data;
  endtask
  // supply drops and returns; long wait covers sync and divide
  task automatic pcyc();
    @(negedge clk);
    power_cycle = 1'b0;
    repeat (4) @(negedge clk);
    power_cycle = 1'b1;
    repeat (60) @(negedge clk);
  endtask
endmodule
`default_nettype wire

//--- bench/grs_top_test.sv
// self-checking bench for the gear resolution block
`default_nettype none
module grs_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [15:0] num; logic [15:0] den; logic [29:0] res; logic warn;} grs_row_t;
  logic clk, rst, wr_en, copy_cmd, config_cmd, alarm_clr, power_cycle, wr_ack, wr_err;
  logic res_valid, gear_warn, gear_alarm, using_sensor, pos_recalc, preset_redo;
  logic [3:0] wr_sel, rd_sel;
  logic [15:0] wr_data, rd_data, v;
  logic [29:0] resolution;
  logic [1:0] r;
  int n_errors = 0;
  int cmp_count = 0;
  int n_recalc = 0;
  logic sen_pres = 1'b1;
  // sensor fixed gears 6 over 10, i.e. 6000 per rev
  localparam logic [15:0] SEN_DEN = 16'h000a;
  localparam logic [15:0] SEN_NUM = 16'h0006;
  // boundaries: 100 exact, 99, 10000 exact, 9999 with remainder, field maximum
  grs_row_t rows [8] = '{'{16'h0006, 16'h000a, 30'h1770, 1'b0}, '{16'h0024, 16'h0064, 30'h0e10, 1'b0},
    '{16'h0001, 16'h0064, 30'h0064, 1'b0}, '{16'h0001, 16'h0065, 30'h0063, 1'b1},
    '{16'h0001, 16'h0001, 30'h2710, 1'b0}, '{16'h0002, 16'h0001, 30'h4e20, 1'b1},
    '{16'h2710, 16'h2711, 30'h270f, 1'b0}, '{16'hffff, 16'hffff, 30'h2710, 1'b0}};
  // select and expected word after reset
  logic [19:0] rdt [8] = '{20'h00000, 20'h1000a, 20'h20006, 20'h40000, 20'h50001, 20'h60001, 20'h9000a,
    20'ha0006};
  grs_top dut (.clk, .rst, .wr_en, .wr_sel, .wr_data, .copy_cmd, .config_cmd, .alarm_clr, .rd_sel,
    .power_cycle, .sensor_present(sen_pres), .sensor_den(SEN_DEN), .sensor_num(SEN_NUM), .rd_data, .wr_ack,
    .wr_err, .resolution, .res_valid, .gear_warn, .gear_alarm, .using_sensor, .pos_recalc, .preset_redo);
  grs_host host (.clk, .wr_ack, .wr_err, .rd_data, .wr_en, .wr_sel, .wr_data, .copy_cmd, .config_cmd,
    .alarm_clr, .rd_sel, .power_cycle);
  // =====
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // count position recalculations, a pulse is easy to miss otherwise
  always @(posedge clk) begin
    if (pos_recalc === 1'b1) n_recalc++;
  end
  // watchdog, run needs about 1000 cycles
  initial begin
    #(100 * 6000);
    n_errors++;
    summarize();
  end
  // =====
  // main sequence
  initial begin
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk(resolution, 30'h2710);
    repeat (45) @(negedge clk);
    chk(using_sensor, 1'b1);
    chk(resolution, 30'h1770);
    foreach (rdt[i]) begin
      host.rd(rdt[i][19:16], v);
      chk(v, rdt[i][15:0]);
    end
    host.req(4'h8, 4'h2, 16'h0003, r);
    chk(r, 2'b01);
    host.req(4'h8, 4'h9, 16'h0003, r);
    chk(r, 2'b01);
    host.req(4'h8, 4'h4, 16'h0002, r);
    chk(r, 2'b01);
    chk(using_sensor, 1'b1);
    host.req(4'h8, 4'h4, 16'h0001, r);
    chk(r, 2'b10);
    repeat (2) @(negedge clk);
    chk(using_sensor, 1'b0);
    host.rd(4'h0, v);
    chk(v, 16'h0000);
    host.pcyc();
    host.rd(4'h0, v);
    chk(v, 16'h0001);
    host.rd(4'h1, v);
    chk(v, 16'h0001);
    // manual numerator, then bulk copy of the sensor gears
    host.req(4'h8, 4'h2, 16'h0003, r);
    host.req(4'h4, 4'h0, 16'h0000, r);
    chk(r, 2'b10);
    host.rd(4'h1, v);
    chk(v, 16'h0001);
    host.pcyc();
    host.rd(4'h1, v);
    chk(v, SEN_DEN);
    host.rd(4'h2, v);
    chk(v, 16'h0003);
    chk(resolution, 30'h0bb8);
    host.req(4'h8, 4'h1, 16'h0000, r);
    chk(r, 2'b01);
    foreach (rows[i]) begin
      host.req(4'h8, 4'h2, rows[i].num, r);
      chk(r, 2'b10);
      repeat (40) @(negedge clk);
      host.req(4'h8, 4'h1, rows[i].den, r);
      chk(r, 2'b10);
      repeat (40) @(negedge clk);
      chk(resolution, rows[i].res);
      chk(gear_warn, rows[i].warn);
    end
    chk(n_recalc > 0, 1'b1);
    // warning, then reconfiguration turns it into an alarm
    host.req(4'h8, 4'h2, 16'h0002, r);
    host.req(4'h8, 4'h1, 16'h0001, r);
    // two writes back to back queue two divides
    repeat (70) @(negedge clk);
    chk(gear_warn, 1'b1);
    chk(gear_alarm, 1'b0);
    host.req(4'h2, 4'h0, 16'h0000, r);
    repeat (2) @(negedge clk);
    chk(gear_alarm, 1'b1);
    host.req(4'h1, 4'h0, 16'h0000, r);
    repeat (2) @(negedge clk);
    chk(gear_alarm, 1'b0);
    // nonzero preset then a resolution change asks for a new preset
    host.req(4'h8, 4'h3, 16'h0005, r);
    host.req(4'h8, 4'h2, 16'h0003, r);
    repeat (40) @(negedge clk);
    chk(preset_redo, 1'b1);
    // sensor unplugged: copy refused, presence view follows after sync
    sen_pres = 1'b0;
    repeat (3) @(negedge clk);
    host.req(4'h4, 4'h0, 16'h0000, r);
    chk(r, 2'b01);
    host.rd(4'h8, v);
    chk(v, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
